// ### verilog/switch_node_config_regs.sv
// Purpose: configuration and status register bank of the message switch node
// Assumes: pll clock is mclk; configuration port addressed by register number
// Notes:   derived clocks leave as one-cycle ticks at the divided rate
// Behaviour
// RULE1 - PLL output divider, bits 25:23, writable
// RULE2 - PLL feedback multiplier, bits 20:8, writable
// RULE3 - PLL input divider, bits 6:0, writable
// RULE4 - PLL fields start from boot strap pins
// RULE5 - switch clock = pll / (divider+1), resets 0
// RULE6 - reference clock = pll / (divider+1), resets 3
// RULE7 - eight direction entries for low id bits
// RULE8 - route by most significant mismatching id bit
// RULE9 - debug source bit 4 marks pin event
// RULE10 - debug source bit 0 marks tile event
// RULE11 - eight link registers from 0x20, order CDABGHEF
// RULE12 - bits 25:24 show inbound destination link type
// RULE13 - bits 23:16 show inbound destination link number
// RULE14 - writable 4-bit link direction, bits 11:8
// RULE15 - writable 2-bit link network, bits 5:4
// RULE16 - bit 2 set while packet is junk
// RULE17 - bit 1 set while routing out into link
// RULE18 - bit 0 set while inbound route exists
// RULE19 - software uses configuration reads and writes
// RULE20 - reserved bits read zero, ignore writes
// RULE21 - divider change without runt pulses
`timescale 1ns/1ps
module switch_node_config_regs (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              cfg_wr,
    input  wire logic              cfg_rd,
    input  wire logic [7:0]        cfg_addr,
    input  wire logic [31:0]       cfg_wdata,
    output logic      [31:0]       cfg_rdata,
    output logic                   cfg_rvalid,
    input  wire logic              boot_strap_pin_zero,
    input  wire logic              boot_strap_pin_one,
    output logic      [2:0]        pll_post_divider,
    output logic      [12:0]       pll_feedback_mult,
    output logic      [6:0]        pll_input_divider,
    output logic                   switch_clk_tick,
    output logic                   ref_clk_tick,
    input  wire logic              route_req,
    input  wire logic [7:0]        route_dest_id,
    input  wire logic [7:0]        local_node_id,
    output logic                   route_done,
    output logic                   route_local,
    output logic      [3:0]        route_dir,
    input  wire logic              dbg_pin_event,
    input  wire logic              dbg_tile_event,
    input  wire logic [7:0]        link_in_route,
    input  wire logic [7:0]        link_out_route,
    input  wire logic [7:0]        link_junk,
    input  wire logic [7:0][1:0]   link_dst_type,
    input  wire logic [7:0][7:0]   link_dst_num,
    output logic      [7:0][3:0]   link_dir,
    output logic      [7:0][1:0]   link_net
);
    logic [2:0]  pll_od_r;
    logic [12:0] pll_fb_r;
    logic [6:0]  pll_rdiv_r;
    logic        strap_done_r;
    logic [15:0] sw_div_r;
    logic [15:0] ref_div_r;
    logic [31:0] dir_table_r;
    logic        dbg_pin_r;
    logic        dbg_tile_r;
    logic [31:0] rdata_r;
    logic [31:0] rd_nxt;
    logic        rvalid_r;
    logic        route_done_r;
    logic        route_local_r;
    logic [3:0]  route_dir_r;
    logic [7:0]  mismatch;
    logic [2:0]  msb_idx;
    logic        link_sel;
    logic [31:0] link_word [8];

    node_cfg_pkg::pll_cfg_t strap_cfg;

    clk_div_if sw_if ();
    clk_div_if ref_if ();

    function automatic logic [2:0] msb_index(input logic [7:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 0; i < 8; i++)
        begin
            if (v[i])
                idx = 3'(i);
        end
        return idx;
    endfunction

    function automatic logic wr_hit(input logic [7:0] reg_num);
        return cfg_wr && (cfg_addr == reg_num);
    endfunction

    // one decode for all eight link slots keeps the write and read windows identical
    function automatic logic link_wr_hit(input logic [2:0] idx);
        return cfg_wr && link_sel && (cfg_addr[2:0] == idx);
    endfunction

    assign link_sel  = (cfg_addr[7:3] == node_cfg_pkg::REG_LINK_BASE[7:3]); // [RULE11]
    assign strap_cfg = node_cfg_pkg::STRAP_PLL[{boot_strap_pin_one, boot_strap_pin_zero}];

    // straps are caught on the first edge after release, never in the reset branch
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            strap_done_r <= 1'b0;
        else
            strap_done_r <= 1'b1;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pll_od_r   <= 3'h0;
            pll_fb_r   <= 13'h0000;
            pll_rdiv_r <= 7'h00;
        end
        else if (!strap_done_r)
        begin
            pll_od_r   <= strap_cfg.od;   // [RULE4]
            pll_fb_r   <= strap_cfg.fb;   // [RULE4]
            pll_rdiv_r <= strap_cfg.rdiv; // [RULE4]
        end
        else if (wr_hit(node_cfg_pkg::REG_PLL)) // [RULE19]
        begin
            pll_od_r   <= cfg_wdata[node_cfg_pkg::PLL_OD_LSB +: node_cfg_pkg::PLL_OD_W]; // [RULE1]
            pll_fb_r   <= cfg_wdata[node_cfg_pkg::PLL_F_LSB +: node_cfg_pkg::PLL_F_W];   // [RULE2]
            pll_rdiv_r <= cfg_wdata[node_cfg_pkg::PLL_R_LSB +: node_cfg_pkg::PLL_R_W];   // [RULE3]
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sw_div_r  <= node_cfg_pkg::SW_DIV_RST;  // [RULE5]
            ref_div_r <= node_cfg_pkg::REF_DIV_RST; // [RULE6]
        end
        else
        begin
            if (wr_hit(node_cfg_pkg::REG_SW_DIV))
                sw_div_r <= cfg_wdata[15:0];        // [RULE5]
            if (wr_hit(node_cfg_pkg::REG_REF_DIV))
                ref_div_r <= cfg_wdata[15:0];       // [RULE6]
        end
    end

    assign sw_if.divisor  = sw_div_r;
    assign ref_if.divisor = ref_div_r;

    clk_div #(.RST_DIV(node_cfg_pkg::SW_DIV_RST)) u_sw_div (
        .mclk (mclk),
        .rst  (rst),
        .dv   (sw_if)
    );

    clk_div #(.RST_DIV(node_cfg_pkg::REF_DIV_RST)) u_ref_div (
        .mclk (mclk),
        .rst  (rst),
        .dv   (ref_if)
    );

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            dir_table_r <= 32'h00000000;
        else if (wr_hit(node_cfg_pkg::REG_DIR_LOW))
            dir_table_r <= cfg_wdata;                 // [RULE7]
    end

    // only the low eight id bits are compared; higher mismatches are the switch core's job
    assign mismatch = route_dest_id ^ local_node_id;
    assign msb_idx  = msb_index(mismatch);            // [RULE8]

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            route_local_r <= 1'b0;
            route_dir_r   <= 4'h0;
        end
        else
        begin
            if (route_req)
            begin
                route_local_r <= (mismatch == 8'h00);
                route_dir_r   <= dir_table_r[msb_idx*node_cfg_pkg::DIR_W +: node_cfg_pkg::DIR_W]; // [RULE8]
            end
        end
    end

    // done pulses for every request, even when the result repeats the last one
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            route_done_r <= 1'b0;
        else
            route_done_r <= route_req; // [RULE8]
    end

    // hardware events win over a software write in the same cycle
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            dbg_pin_r  <= 1'b0;
            dbg_tile_r <= 1'b0;
        end
        else if (dbg_pin_event || dbg_tile_event)
        begin
            dbg_pin_r  <= dbg_pin_event;  // [RULE9]
            dbg_tile_r <= dbg_tile_event; // [RULE10]
        end
        else if (wr_hit(node_cfg_pkg::REG_DBG_SRC))
        begin
            dbg_pin_r  <= cfg_wdata[node_cfg_pkg::DBG_PIN_BIT];  // [RULE9]
            dbg_tile_r <= cfg_wdata[node_cfg_pkg::DBG_TILE_BIT]; // [RULE10]
        end
    end

    // index 0..7 stands for links C, D, A, B, G, H, E, F
    genvar g;
    generate
        for (g = 0; g < node_cfg_pkg::NUM_LINKS; g++)
        begin : g_link
            logic       in_r;
            logic       out_r;
            logic       junk_r;
            logic [1:0] type_r;
            logic [7:0] dst_r;
            logic [3:0] dir_r;
            logic [1:0] net_r;

            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                begin
                    in_r   <= 1'b0;
                    out_r  <= 1'b0;
                    junk_r <= 1'b0;
                    type_r <= node_cfg_pkg::LT_PROC;
                    dst_r  <= 8'h00;
                end
                else
                begin
                    in_r   <= link_in_route[g];  // [RULE18]
                    out_r  <= link_out_route[g]; // [RULE17]
                    junk_r <= link_junk[g];      // [RULE16]
                    // destination fields only mean something while routing in
                    type_r <= link_in_route[g] ? link_dst_type[g] : 2'h0; // [RULE12]
                    dst_r  <= link_in_route[g] ? link_dst_num[g] : 8'h00; // [RULE13]
                end
            end

            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                begin
                    dir_r <= 4'h0;
                    net_r <= 2'h0;
                end
                else if (link_wr_hit(3'(g))) // [RULE11]
                begin
                    dir_r <= cfg_wdata[node_cfg_pkg::LS_DIR_LSB +: node_cfg_pkg::DIR_W]; // [RULE14]
                    net_r <= cfg_wdata[node_cfg_pkg::LS_NET_LSB +: node_cfg_pkg::NET_W]; // [RULE15]
                end
            end

            always_comb
            begin
                link_word[g] = 32'h00000000;
                link_word[g][node_cfg_pkg::LS_TYPE_LSB +: 2] = type_r;                 // [RULE12]
                link_word[g][node_cfg_pkg::LS_DST_LSB +: 8]  = dst_r;                  // [RULE13]
                link_word[g][node_cfg_pkg::LS_DIR_LSB +: node_cfg_pkg::DIR_W] = dir_r; // [RULE14]
                link_word[g][node_cfg_pkg::LS_NET_LSB +: node_cfg_pkg::NET_W] = net_r; // [RULE15]
                link_word[g][node_cfg_pkg::LS_JUNK_BIT] = junk_r;                      // [RULE16]
                link_word[g][node_cfg_pkg::LS_OUT_BIT]  = out_r;                       // [RULE17]
                link_word[g][node_cfg_pkg::LS_IN_BIT]   = in_r;                        // [RULE18]
            end

            assign link_dir[g] = dir_r;
            assign link_net[g] = net_r;
        end
    endgenerate

    // reserved bits and unmapped numbers read zero  [RULE20]
    always_comb
    begin
        rd_nxt = 32'h00000000;
        if (link_sel)
            rd_nxt = link_word[cfg_addr[2:0]];
        else
        begin
            case (cfg_addr)
                node_cfg_pkg::REG_PLL:
                begin
                    rd_nxt[node_cfg_pkg::PLL_OD_LSB +: node_cfg_pkg::PLL_OD_W] = pll_od_r;   // [RULE1]
                    rd_nxt[node_cfg_pkg::PLL_F_LSB +: node_cfg_pkg::PLL_F_W]   = pll_fb_r;   // [RULE2]
                    rd_nxt[node_cfg_pkg::PLL_R_LSB +: node_cfg_pkg::PLL_R_W]   = pll_rdiv_r; // [RULE3]
                end
                node_cfg_pkg::REG_SW_DIV:  rd_nxt[15:0] = sw_div_r;
                node_cfg_pkg::REG_REF_DIV: rd_nxt[15:0] = ref_div_r;
                node_cfg_pkg::REG_DIR_LOW: rd_nxt = dir_table_r;
                node_cfg_pkg::REG_DBG_SRC:
                begin
                    rd_nxt[node_cfg_pkg::DBG_PIN_BIT]  = dbg_pin_r;
                    rd_nxt[node_cfg_pkg::DBG_TILE_BIT] = dbg_tile_r;
                end
                default: rd_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rdata_r  <= 32'h00000000;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rvalid_r <= cfg_rd; // [RULE19]
            if (cfg_rd)
                rdata_r <= rd_nxt;
        end
    end

    assign cfg_rdata         = rdata_r;
    assign cfg_rvalid        = rvalid_r;
    assign pll_post_divider  = pll_od_r;
    assign pll_feedback_mult = pll_fb_r;
    assign pll_input_divider = pll_rdiv_r;
    assign switch_clk_tick   = sw_if.tick;
    assign ref_clk_tick      = ref_if.tick;
    assign route_done        = route_done_r;
    assign route_local       = route_local_r;
    assign route_dir         = route_dir_r;
endmodule // switch_node_config_regs

// ### verilog/node_cfg_pkg.sv
// Purpose: constants and types shared by the switch node configuration bank
// Assumes: register numbers are word indexes on the configuration port
// Notes:   strap table values are plain defaults for the boot-time PLL setup
package node_cfg_pkg;
    localparam logic [7:0] REG_PLL       = 8'h06;
    localparam logic [7:0] REG_SW_DIV    = 8'h07;
    localparam logic [7:0] REG_REF_DIV   = 8'h08;
    localparam logic [7:0] REG_DIR_LOW   = 8'h0C;
    localparam logic [7:0] REG_DBG_SRC   = 8'h1F;
    localparam logic [7:0] REG_LINK_BASE = 8'h20;
    localparam int         NUM_LINKS     = 8;

    localparam int PLL_OD_LSB = 23;
    localparam int PLL_OD_W   = 3;
    localparam int PLL_F_LSB  = 8;
    localparam int PLL_F_W    = 13;
    localparam int PLL_R_LSB  = 0;
    localparam int PLL_R_W    = 7;

    localparam int              DIV_W       = 16;
    localparam logic [DIV_W-1:0] SW_DIV_RST  = 16'h0000;
    localparam logic [DIV_W-1:0] REF_DIV_RST = 16'h0003;

    localparam int DBG_PIN_BIT  = 4;
    localparam int DBG_TILE_BIT = 0;

    localparam int DIR_ENTRIES = 8;
    localparam int DIR_W       = 4;

    localparam int LS_TYPE_LSB = 24;
    localparam int LS_DST_LSB  = 16;
    localparam int LS_DIR_LSB  = 8;
    localparam int LS_NET_LSB  = 4;
    localparam int LS_JUNK_BIT = 2;
    localparam int LS_OUT_BIT  = 1;
    localparam int LS_IN_BIT   = 0;
    localparam int NET_W       = 2;

    typedef enum logic [1:0] {
        LT_PROC = 2'b00,
        LT_EXT  = 2'b01,
        LT_CTRL = 2'b10
    } link_type_t;

    typedef struct packed {
        logic [PLL_OD_W-1:0] od;
        logic [PLL_F_W-1:0]  fb;
        logic [PLL_R_W-1:0]  rdiv;
    } pll_cfg_t;

    // indexed by {boot_strap_pin_one, boot_strap_pin_zero}
    localparam pll_cfg_t STRAP_PLL [4] = '{
        '{od: 3'h1, fb: 13'h0007, rdiv: 7'h00},
        '{od: 3'h1, fb: 13'h000F, rdiv: 7'h01},
        '{od: 3'h2, fb: 13'h001F, rdiv: 7'h01},
        '{od: 3'h0, fb: 13'h0003, rdiv: 7'h00}
    };
endpackage

// ### verilog/clk_div_if.sv
// Purpose: carries a divisor to a clock divider and its period tick back
// Assumes: single clock domain
// Notes:   ctl side owns the divisor, div side owns the tick
`timescale 1ns/1ps
interface clk_div_if;
    logic [15:0] divisor;
    logic        tick;
    modport ctl (output divisor, input tick);
    modport div (input divisor, output tick);
endinterface

// ### verilog/clk_div.sv
// Purpose: divide the pll clock by divisor plus one as a one-cycle tick
// Assumes: mclk stands in for the pll clock
// Notes:   new divisor is only adopted at a period boundary
`timescale 1ns/1ps
module clk_div #(
    parameter logic [15:0] RST_DIV = 16'h0000
) (
    input wire logic mclk,
    input wire logic rst,
    clk_div_if.div   dv
);
    logic [15:0] cnt_r;
    logic [15:0] div_r;
    logic        tick_r;

    // latching the divisor only at wrap avoids a runt period  [RULE21]
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cnt_r <= 16'h0000;
            div_r <= RST_DIV;
        end
        else if (cnt_r >= div_r)
        begin
            cnt_r <= 16'h0000;
            div_r <= dv.divisor;
        end
        else
        begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    // one tick per divisor plus one cycles  [RULE5] [RULE6]
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            tick_r <= 1'b0;
        else
            tick_r <= (cnt_r >= div_r);
    end

    assign dv.tick = tick_r;
endmodule // clk_div

// ### bench/switch_node_config_properties.sv
// Purpose: port-level properties of the node configuration bank
// Assumes: one clock, async active-high reset
// Notes:   shadows rebuilt from port writes; a table write racing a lookup is checked against the new table
`timescale 1ns/1ps
module switch_node_config_properties (
    input wire logic            mclk,
    input wire logic            rst,
    input wire logic            cfg_wr,
    input wire logic            cfg_rd,
    input wire logic [7:0]      cfg_addr,
    input wire logic [31:0]     cfg_wdata,
    input wire logic [31:0]     cfg_rdata,
    input wire logic            cfg_rvalid,
    input wire logic [2:0]      pll_post_divider,
    input wire logic [12:0]     pll_feedback_mult,
    input wire logic [6:0]      pll_input_divider,
    input wire logic            route_req,
    input wire logic [7:0]      route_dest_id,
    input wire logic [7:0]      local_node_id,
    input wire logic            route_done,
    input wire logic            route_local,
    input wire logic [3:0]      route_dir,
    input wire logic            dbg_pin_event,
    input wire logic            dbg_tile_event,
    input wire logic [7:0][3:0] link_dir
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic        up_r;
    logic [31:0] dir_r;
    logic [31:0] wd_r;
    logic [7:0]  ad_r;
    logic [7:0]  mm_r;

    // up_r masks the strap-load edge, where a pll write is dropped
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            up_r <= 1'b0;
        else
            up_r <= 1'b1;
    end
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            dir_r <= 32'h0000_0000;
        else if (cfg_wr && cfg_addr == node_cfg_pkg::REG_DIR_LOW)
            dir_r <= cfg_wdata;
    end
    always_ff @(posedge mclk)
    begin
        wd_r <= cfg_wdata;
        ad_r <= cfg_addr;
        mm_r <= route_dest_id ^ local_node_id;
    end

    function automatic logic [3:0] entry(input logic [7:0] m, input logic [31:0] t);
        int k;
        k = 0;
        for (int i = 0; i < 8; i++)
            if (m[i])
                k = i;
        return t[k*4 +: 4];
    endfunction

    sequence s_pll_wr;
        up_r && cfg_wr && cfg_addr == node_cfg_pkg::REG_PLL;
    endsequence
    sequence s_pin_then_rd;
        dbg_pin_event && !dbg_tile_event ##1 cfg_rd && cfg_addr == node_cfg_pkg::REG_DBG_SRC;
    endsequence

    property p_rd; cfg_rd |=> cfg_rvalid; endproperty
    property p_no_rd; !cfg_rd |=> !cfg_rvalid; endproperty
    property p_done; route_req |=> route_done; endproperty
    property p_local; route_req && route_dest_id == local_node_id |=> route_local; endproperty
    property p_dir;
        route_req && route_dest_id != local_node_id |=> !route_local && route_dir == entry(mm_r, dir_r);
    endproperty
    property p_pll;
        s_pll_wr |=> pll_post_divider == wd_r[25:23] && pll_feedback_mult == wd_r[20:8]
            && pll_input_divider == wd_r[6:0];
    endproperty
    property p_link; cfg_wr && cfg_addr[7:3] == 5'h04 |=> link_dir[ad_r[2:0]] == wd_r[11:8]; endproperty
    property p_dbg; s_pin_then_rd |=> cfg_rdata[4:0] == 5'h10; endproperty
    property p_rsv;
        cfg_rd && (cfg_addr == node_cfg_pkg::REG_SW_DIV || cfg_addr == 8'h01) |=> cfg_rdata[31:16] == 16'h0000;
    endproperty

    a_rd: assert property (p_rd) else $error("read not answered");
    a_no_rd: assert property (p_no_rd) else $error("stray read valid");
    a_done: assert property (p_done) else $error("route lookup not done");
    a_local: assert property (p_local) else $error("equal ids not local");
    a_dir: assert property (p_dir) else $error("wrong route direction");
    a_pll: assert property (p_pll) else $error("pll fields not written");
    a_link: assert property (p_link) else $error("link direction not written");
    a_dbg: assert property (p_dbg) else $error("pin event not recorded");
    a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
endmodule // switch_node_config_properties

bind switch_node_config_regs switch_node_config_properties u_props (.mclk, .rst, .cfg_wr, .cfg_rd, .cfg_addr,
    .cfg_wdata, .cfg_rdata, .cfg_rvalid, .pll_post_divider, .pll_feedback_mult, .pll_input_divider, .route_req,
    .route_dest_id, .local_node_id, .route_done, .route_local, .route_dir, .dbg_pin_event, .dbg_tile_event,
    .link_dir);

// ### bench/tb_top.sv
// Purpose: self-checking bench for the node configuration bank
// Assumes: inputs change 1 ns after the rising edge
// Notes:   random stimulus from a fixed seed with hand-picked corners
`timescale 1ns/1ps
module tb_top;
    logic             mclk = 1'b0;
    logic             rst = 1'b1;
    logic             cfg_wr = 1'b0;
    logic             cfg_rd = 1'b0;
    logic [7:0]       cfg_addr = 8'h00;
    logic [31:0]      cfg_wdata = 32'h0;
    logic [31:0]      cfg_rdata;
    logic             cfg_rvalid;
    logic             boot_strap_pin_zero = 1'b0;
    logic             boot_strap_pin_one = 1'b0;
    logic [2:0]       pll_post_divider;
    logic [12:0]      pll_feedback_mult;
    logic [6:0]       pll_input_divider;
    logic             switch_clk_tick;
    logic             ref_clk_tick;
    logic             route_req = 1'b0;
    logic [7:0]       route_dest_id = 8'h00;
    logic [7:0]       local_node_id = 8'h00;
    logic             route_done;
    logic             route_local;
    logic [3:0]       route_dir;
    logic             dbg_pin_event = 1'b0;
    logic             dbg_tile_event = 1'b0;
    logic [7:0]       link_in_route = 8'h00;
    logic [7:0]       link_out_route = 8'h00;
    logic [7:0]       link_junk = 8'h00;
    logic [7:0][1:0]  link_dst_type = 16'h0;
    logic [7:0][7:0]  link_dst_num = 64'h0;
    logic [7:0][3:0]  link_dir;
    logic [7:0][1:0]  link_net;
    logic [7:0][31:0] lw;
    int               err_total = 0;
    int               checked = 0;

    switch_node_config_regs u_switch_node_config_regs (.*);

    always #2.5 mclk = ~mclk;

    task automatic stop_test;
        if (err_total == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tk;
        @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // the idle cycle after each access keeps strobes from being reasserted in the same step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        tk;
        cfg_wr = 1'b0;
        tk;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        cfg_rd = 1'b1;
        cfg_addr = a;
        tk;
        cfg_rd = 1'b0;
        chk("cfg_rvalid", 32'h1, {31'h0, cfg_rvalid});
        chk($sformatf("reg %h", a), e, cfg_rdata);
        tk;
    endtask
    function automatic logic [31:0] pllv(input node_cfg_pkg::pll_cfg_t p);
        return {6'h00, p.od, 2'h0, p.fb, 1'b0, p.rdiv};
    endfunction
    task automatic rs(input logic [1:0] s);
        rst = 1'b1;
        {boot_strap_pin_one, boot_strap_pin_zero} = s;
        repeat (3) @(posedge mclk);
        #1;
        rst = 1'b0;
        tk;
        chk("pll pins", 32'(node_cfg_pkg::STRAP_PLL[s]),
            32'({pll_post_divider, pll_feedback_mult, pll_input_divider}));
        rc(node_cfg_pkg::REG_PLL, pllv(node_cfg_pkg::STRAP_PLL[s]));
    endtask
    function automatic logic tick(input logic w);
        return w ? ref_clk_tick : switch_clk_tick;
    endfunction
    task automatic per(input logic w, output int n);
        n = 0;
        while (tick(w) !== 1'b1 && n < 99)
        begin
            tk;
            n++;
        end
        n = 0;
        do
        begin
            tk;
            n++;
        end
        while (tick(w) !== 1'b1 && n < 99);
    endtask
    function automatic logic [4:0] rexp(input logic [7:0] m, input logic [31:0] t);
        int k;
        k = 0;
        for (int i = 0; i < 8; i++)
            if (m[i])
                k = i;
        return {m == 8'h00, t[k*4 +: 4]};
    endfunction
    function automatic logic [31:0] lexp(input int i);
        logic ir;
        ir = link_in_route[i];
        return {6'h00, ir ? link_dst_type[i] : 2'h0, ir ? link_dst_num[i] : 8'h00, 4'h0, lw[i][11:8],
                2'h0, lw[i][5:4], 1'b0, link_junk[i], link_out_route[i], ir};
    endfunction

    initial
    begin
        logic [31:0] w;
        logic [31:0] t;
        int          n;
        w = $urandom(32'h1F5FAD23);
        for (int s = 0; s < 4; s++)
            rs(2'(s));
        rc(node_cfg_pkg::REG_SW_DIV, 32'h0);
        rc(node_cfg_pkg::REG_REF_DIV, 32'h3);
        wr(8'h30, 32'hFFFF_FFFF);
        rc(8'h30, 32'h0);
        rc(8'h01, 32'h0);
        per(1'b0, n);
        chk("switch period", 32'h1, 32'(n));
        per(1'b1, n);
        chk("ref period", 32'h4, 32'(n));
        for (int k = 0; k < 6; k++)
        begin
            w = $urandom;
            t = $urandom_range(9, 0);
            wr(k[0] ? node_cfg_pkg::REG_REF_DIV : node_cfg_pkg::REG_SW_DIV, {w[31:16], t[15:0]});
            rc(k[0] ? node_cfg_pkg::REG_REF_DIV : node_cfg_pkg::REG_SW_DIV, t);
            repeat (3) per(k[0], n);
            chk("divided period", t + 32'h1, 32'(n));
        end
        for (int k = 0; k < 6; k++)
        begin
            w = (k == 0) ? 32'hFFFF_FFFF : $urandom;
            wr(node_cfg_pkg::REG_PLL, w);
            rc(node_cfg_pkg::REG_PLL, w & 32'h039F_FF7F);
        end
        t = $urandom;
        wr(node_cfg_pkg::REG_DIR_LOW, t);
        rc(node_cfg_pkg::REG_DIR_LOW, t);
        route_req = 1'b1;
        for (int k = 0; k < 24; k++)
        begin
            w = $urandom;
            local_node_id = w[7:0];
            route_dest_id = (k < 8) ? w[7:0] ^ (8'h01 << k) : (k == 8) ? w[7:0] : w[15:8];
            tk;
            chk("route_done", 32'h1, {31'h0, route_done});
            chk("route", 32'(rexp(route_dest_id ^ local_node_id, t)), 32'({route_local, route_dir}));
        end
        route_req = 1'b0;
        tk;
        chk("route_done idle", 32'h0, {31'h0, route_done});
        for (int k = 1; k < 4; k++)
        begin
            {dbg_pin_event, dbg_tile_event} = 2'(k);
            tk;
            {dbg_pin_event, dbg_tile_event} = 2'b00;
            rc(node_cfg_pkg::REG_DBG_SRC, {27'h0, k[1], 3'h0, k[0]});
        end
        wr(node_cfg_pkg::REG_DBG_SRC, 32'hFFFF_FFFF);
        rc(node_cfg_pkg::REG_DBG_SRC, 32'h11);
        for (int i = 0; i < 8; i++)
        begin
            lw[i] = $urandom;
            wr(node_cfg_pkg::REG_LINK_BASE + 8'(i), lw[i]);
            chk("link_dir", 32'(lw[i][11:8]), 32'(link_dir[i]));
            chk("link_net", 32'(lw[i][5:4]), 32'(link_net[i]));
        end
        for (int p = 0; p < 2; p++)
        begin
            w = $urandom;
            link_in_route = p ? 8'hFF : w[7:0];
            link_out_route = w[15:8];
            link_junk = w[23:16];
            for (int i = 0; i < 8; i++)
            begin
                link_dst_type[i] = 2'((i + p) % 3);
                link_dst_num[i] = 8'($urandom);
            end
            tk;
            for (int i = 0; i < 8; i++)
                rc(node_cfg_pkg::REG_LINK_BASE + 8'(i), lexp(i));
        end
        stop_test;
    end

    initial
    begin
        #200000;
        err_total++;
        stop_test;
    end
endmodule // tb_top
